// ==== rtl/ebtb_regs.vh ====
/*
  Constants for the eight-bit interval / time-base timer: register indices,
  field positions, reset values and prescaler tap masks.
  Assumes a 32-bit AHB-Lite register bus, where each register index sits on
  one aligned word (byte address = four times the index).
*/
`ifndef EBTB_REGS_VH
`define EBTB_REGS_VH

// register indices; byte address is index * 4
`define EBTB_IDX_MODE        16'hffb0
`define EBTB_IDX_COUNT       16'hffb1
`define EBTB_IDX_STATUS      16'hffbc
`define EBTB_IDX_MASK        16'hffbd
`define EBTB_IDX_CONTROL     16'hffbe

// reset values
`define EBTB_MODE_RESET      8'h10
`define EBTB_COUNT_RESET     8'h00
`define EBTB_STATUS_RESET    1'b0
`define EBTB_MASK_RESET      1'b0
`define EBTB_CONTROL_RESET   1'b0

// mode register fields
`define EBTB_OUTSEL_MSB      7
`define EBTB_OUTSEL_LSB      5
`define EBTB_RSVD_BIT        4
`define EBTB_TBSEL_BIT       3
`define EBTB_HOLD_BIT        2
`define EBTB_CKSEL_MSB       1
`define EBTB_CKSEL_LSB       0

// own registers: overflow flag, its enable, clock-out enable, all at bit 0
`define EBTB_FLAG_BIT        0

// operating modes seen on the op_mode input
`define EBTB_OPM_ACTIVE      2'h0
`define EBTB_OPM_SLEEP       2'h1
`define EBTB_OPM_SUBACTIVE   2'h2

// system prescaler taps for interval mode, codes 000 to 111
`define EBTB_SYS_MASK_8192   13'h1fff
`define EBTB_SYS_MASK_4096   13'h0fff
`define EBTB_SYS_MASK_2048   13'h07ff
`define EBTB_SYS_MASK_512    13'h01ff
`define EBTB_SYS_MASK_256    13'h00ff
`define EBTB_SYS_MASK_128    13'h007f
`define EBTB_SYS_MASK_32     13'h001f
`define EBTB_SYS_MASK_8      13'h0007

// subclock prescaler taps for overflow periods 1 s, 0.5 s, 0.25 s, 0.03125 s
`define EBTB_SUB_MASK_128    7'h7f
`define EBTB_SUB_MASK_64     7'h3f
`define EBTB_SUB_MASK_32     7'h1f
`define EBTB_SUB_MASK_4      7'h03

`endif

// ==== rtl/ebtb_sub_prescaler.v ====
/*
  Subclock prescaler: brings the slow subclock pin into the system clock
  domain and counts its rising edges.
  Assumes the subclock is far slower than the system clock, so every
  subclock rising edge is seen as one system clock pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module ebtb_sub_prescaler #(
  parameter WIDTH = 7
) (
  // clock and reset
  input  wire             clock,
  input  wire             reset_n,
  // subclock pin and hold
  input  wire             sub_clock_pin,
  input  wire             clear,
  // prescaler state
  output reg  [WIDTH-1:0] sub_count,
  output reg              sub_step
);

  reg sync_first;
  reg sync_second;
  reg sync_last;

  // first stage is read only by the second stage
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      sync_last   <= 1'b0;
    end else begin
      sync_first  <= sub_clock_pin;
      sync_second <= sync_first;
      sync_last   <= sync_second;
    end
  end

  // one step per subclock rising edge; a held clear keeps it at zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sub_count <= {WIDTH{1'b0}};
      sub_step  <= 1'b0;
    end else if (clear) begin
      sub_count <= {WIDTH{1'b0}};
      sub_step  <= 1'b0;
    end else begin
      sub_step <= sync_second & ~sync_last;
      if (sync_second & ~sync_last) begin
        sub_count <= sub_count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ebtb_timer.v ====
/*
  Eight-bit interval / time-base timer with divided clock output, reached
  over an AHB-Lite slave port with zero wait states.
  Assumes a single system clock; the subclock arrives as a pin and is
  sampled, and the operating mode comes from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

`include "ebtb_regs.vh"

module ebtb_timer #(
  parameter SYS_PSC_WIDTH = 13,
  parameter SUB_PSC_WIDTH = 7
) (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // chip context
  input  wire        sub_clock_pin,
  input  wire [1:0]  op_mode,
  // outputs
  output reg         divided_clock_out_pin,
  output reg         irq
);

  // register state
  reg  [7:0]               timer_mode_register;
  reg  [7:0]               up_count_register;
  reg                      overflow_request_flag;
  reg                      overflow_irq_enable;
  reg                      port_mode_reg_one;
  reg  [SYS_PSC_WIDTH-1:0] system_prescaler;

  // bus state
  reg                      wr_pend;
  reg  [15:0]              wr_index;

  // combinational values
  reg  [7:0]               next_mode;
  reg  [7:0]               next_count;
  reg                      next_flag;
  reg                      next_enable;
  reg                      next_out_enable;
  reg  [SYS_PSC_WIDTH-1:0] sys_mask;
  reg  [SUB_PSC_WIDTH-1:0] sub_mask;
  reg                      out_level;
  reg                      out_allowed;
  reg  [7:0]               read_byte;
  reg                      wr_mode;
  reg                      wr_status;
  reg                      wr_mask;
  reg                      wr_control;

  wire [SUB_PSC_WIDTH-1:0] subclock_prescaler;
  wire                     sub_step;
  wire                     time_base_select;
  wire                     tb_hold_clear;
  wire [2:0]               clock_out_select;
  wire                     in_subactive;
  wire                     sys_tick;
  wire                     sub_tick;
  wire                     count_pulse;
  wire                     overflow;
  wire                     addr_phase;
  wire                     rd_req;
  wire [15:0]              rd_index;
  wire                     addr_high_zero;

  assign time_base_select = timer_mode_register[`EBTB_TBSEL_BIT];
  assign tb_hold_clear    = timer_mode_register[`EBTB_HOLD_BIT];
  assign clock_out_select = timer_mode_register[`EBTB_OUTSEL_MSB:`EBTB_OUTSEL_LSB];
  assign in_subactive     = (op_mode == `EBTB_OPM_SUBACTIVE);

  // subclock prescaler, held cleared in time base hold
  ebtb_sub_prescaler #(
    .WIDTH         (SUB_PSC_WIDTH)
  ) u_sub_prescaler (
    .clock         (clock),
    .reset_n       (reset_n),
    .sub_clock_pin (sub_clock_pin),
    .clear         (time_base_select & tb_hold_clear),
    .sub_count     (subclock_prescaler),
    .sub_step      (sub_step)
  );

  // free-running system prescaler; the system clock stops in subactive
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      system_prescaler <= {SYS_PSC_WIDTH{1'b0}};
    end else if (!in_subactive) begin
      system_prescaler <= system_prescaler + {{(SYS_PSC_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // interval tap selection
  always @* begin
    case (timer_mode_register[2:0])
      3'h0: sys_mask = `EBTB_SYS_MASK_8192;
      3'h1: sys_mask = `EBTB_SYS_MASK_4096;
      3'h2: sys_mask = `EBTB_SYS_MASK_2048;
      3'h3: sys_mask = `EBTB_SYS_MASK_512;
      3'h4: sys_mask = `EBTB_SYS_MASK_256;
      3'h5: sys_mask = `EBTB_SYS_MASK_128;
      3'h6: sys_mask = `EBTB_SYS_MASK_32;
      default: sys_mask = `EBTB_SYS_MASK_8;
    endcase
  end

  // time base period selection; count rate 256 Hz gives 1 s per overflow
  always @* begin
    case (timer_mode_register[`EBTB_CKSEL_MSB:`EBTB_CKSEL_LSB])
      2'h0: sub_mask = `EBTB_SUB_MASK_128;
      2'h1: sub_mask = `EBTB_SUB_MASK_64;
      2'h2: sub_mask = `EBTB_SUB_MASK_32;
      default: sub_mask = `EBTB_SUB_MASK_4;
    endcase
  end

  // a sub step lands with the count already advanced, so a wrapped tap
  // field of zero marks the divided edge
  assign sys_tick    = ((system_prescaler & sys_mask) == sys_mask) & ~in_subactive;
  assign sub_tick    = sub_step & ((subclock_prescaler & sub_mask) == {SUB_PSC_WIDTH{1'b0}});

  // interval counting halts in subactive; time base keeps running
  assign count_pulse = time_base_select ? (~tb_hold_clear & sub_tick)
                                        : sys_tick;
  assign overflow    = count_pulse & (up_count_register == 8'hff);

  // bus address phase
  assign addr_phase     = hsel & hready & htrans[1];
  assign rd_req         = addr_phase & ~hwrite;
  assign rd_index       = haddr[17:2];
  assign addr_high_zero = (haddr[31:18] == 14'h0000);

  // write decode for the data phase now on the bus
  always @* begin
    wr_mode    = 1'b0;
    wr_status  = 1'b0;
    wr_mask    = 1'b0;
    wr_control = 1'b0;
    if (wr_pend) begin
      if (wr_index == `EBTB_IDX_MODE) begin
        wr_mode = 1'b1;
      end else if (wr_index == `EBTB_IDX_STATUS) begin
        wr_status = 1'b1;
      end else if (wr_index == `EBTB_IDX_MASK) begin
        wr_mask = 1'b1;
      end else if (wr_index == `EBTB_IDX_CONTROL) begin
        wr_control = 1'b1;
      end
    end
  end

  // bit 4 is forced high, so no write can clear it
  always @*  begin
    next_mode = timer_mode_register;
    if (wr_mode) begin
      next_mode = {hwdata[7:5], 1'b1, hwdata[3:0]};
    end
  end

  // a set beats a clear in the same cycle, so no overflow is lost
  always @* begin
    next_flag = overflow_request_flag;
    if (wr_status & hwdata[`EBTB_FLAG_BIT]) begin
      next_flag = 1'b0;
    end
    if (overflow) begin
      next_flag = 1'b1;
    end
  end

  // mask and clock-out enable are plain single-bit read/write bits
  always @* begin
    next_enable = overflow_irq_enable;
    if (wr_mask) begin
      next_enable = hwdata[`EBTB_FLAG_BIT];
    end
  end

  always @* begin
    next_out_enable = port_mode_reg_one;
    if (wr_control) begin
      next_out_enable = hwdata[`EBTB_FLAG_BIT];
    end
  end

  // counter ignores bus writes entirely
  always @* begin
    next_count = up_count_register;
    if (time_base_select & tb_hold_clear) begin
      next_count = 8'h00;
    end else if (count_pulse) begin
      next_count = up_count_register + 8'h01;
    end
  end

  // one flop group per register keeps each reset value beside its update
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_mode_register <= `EBTB_MODE_RESET;
    end else begin
      timer_mode_register <= next_mode;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      up_count_register <= `EBTB_COUNT_RESET;
    end else begin
      up_count_register <= next_count;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overflow_request_flag <= `EBTB_STATUS_RESET;
    end else begin
      overflow_request_flag <= next_flag;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overflow_irq_enable <= `EBTB_MASK_RESET;
    end else begin
      overflow_irq_enable <= next_enable;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_mode_reg_one <= `EBTB_CONTROL_RESET;
    end else begin
      port_mode_reg_one <= next_out_enable;
    end
  end

  // read mux sees next values, so a read right after a write is current
  always @* begin
    read_byte = 8'h00;
    if (!addr_high_zero) begin
      read_byte = 8'h00;
    end else if (rd_index == `EBTB_IDX_MODE) begin
      read_byte = next_mode | 8'h10;
    end else if (rd_index == `EBTB_IDX_COUNT) begin
      // the cpu has no valid view of the counter in subactive
      read_byte = in_subactive ? 8'h00 : next_count;
    end else if (rd_index == `EBTB_IDX_STATUS) begin
      read_byte = {7'h00, next_flag};
    end else if (rd_index == `EBTB_IDX_MASK) begin
      read_byte = {7'h00, next_enable};
    end else if (rd_index == `EBTB_IDX_CONTROL) begin
      read_byte = {7'h00, next_out_enable};
    end
  end

  // slave never stalls and always answers okay; unmapped reads give zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      wr_index  <= 16'h0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= addr_phase & hwrite & addr_high_zero;
      if (addr_phase) begin
        wr_index <= rd_index;
      end
      if (rd_req) begin
        hrdata <= {24'h000000, read_byte};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // divided clock selection from prescaler bits
  always @* begin
    case (clock_out_select)
      3'h0: out_level = system_prescaler[4];
      3'h1: out_level = system_prescaler[3];
      3'h2: out_level = system_prescaler[2];
      3'h3: out_level = system_prescaler[1];
      3'h4: out_level = subclock_prescaler[4];
      3'h5: out_level = subclock_prescaler[3];
      3'h6: out_level = subclock_prescaler[2];
      default: out_level = subclock_prescaler[1];
    endcase
    if (clock_out_select[2]) begin
      out_allowed = 1'b1;
    end else begin
      out_allowed = (op_mode == `EBTB_OPM_ACTIVE) | (op_mode == `EBTB_OPM_SLEEP);
    end
  end

  // pin and interrupt both come from flip-flops
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divided_clock_out_pin <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      divided_clock_out_pin <= port_mode_reg_one & out_allowed & out_level;
      irq                   <= next_flag & next_enable;
    end
  end

endmodule

`default_nettype wire

// ==== test/ebtb_timer_assertions.sv ====
/*
  Port checker for ebtb_timer: bus answer, read-back of fixed bits and quiet
  outputs after reset.
  Sees only the top module's ports; bound to it at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ebtb_regs.vh"
module ebtb_timer_assertions (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  input  wire logic        hresp,
  // context and outputs
  input  wire logic [1:0]  op_mode,
  input  wire logic        divided_clock_out_pin,
  input  wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic rd = hsel && hready && htrans[1] && !hwrite && haddr[31:18] == 14'h0;
  sequence s_rd(logic [15:0] idx);
    rd && haddr[17:2] == idx;
  endsequence
  sequence s_sub;
    op_mode == `EBTB_OPM_SUBACTIVE;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_idle_data: assert property (!$past(rd) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_rsvd_one: assert property (s_rd(`EBTB_IDX_MODE) |=> hrdata[4] && hrdata[31:8] == 24'h0)
    else $error("mode read lost its fixed one");
  a_count_upper: assert property (s_rd(`EBTB_IDX_COUNT) |=> hrdata[31:8] == 24'h0)
    else $error("count read wider than eight bits");
  a_sub_read: assert property (s_rd(`EBTB_IDX_COUNT) ##0 s_sub ##1 s_sub |-> hrdata == 32'h0)
    else $error("count read valid in subactive");
  a_unmapped_zero: assert property (s_rd(16'h0001) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_quiet: assert property ($rose(reset_n) |-> !irq [*3])
    else $error("interrupt right after reset");
  a_pin_quiet: assert property ($rose(reset_n) |-> !divided_clock_out_pin [*3])
    else $error("clock out right after reset");
endmodule
bind ebtb_timer ebtb_timer_assertions i_chk (
  .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .op_mode(op_mode), .divided_clock_out_pin(divided_clock_out_pin),
  .irq(irq)
);
`default_nettype wire

// ==== test/tb.sv ====
/*
  Self-checking bench for ebtb_timer: AHB-Lite tasks, counts over windows.
  Assumes a subclock sixteen system cycles long, so time-base runs stay short.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ebtb_regs.vh"
module tb;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  op_mode = 2'h0;
  logic [3:0]  sc_cnt = 4'h0;
  logic [31:0] rv;
  logic        prev;
  wire logic        hready;
  wire logic [31:0] hrdata;
  wire logic        clk_out;
  wire logic        irq;
  int          err_count = 0;
  int          checks = 0;
  int          n;
  int          dv[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
  int          sd[4] = '{128, 64, 32, 4};
  logic [2:0]  sel[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 0, 7, 3};
  logic [1:0]  om[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 0};
  always #5 clock = ~clock;
  // stand-in subclock, far faster than the real one to keep the run short
  always @(posedge clock) sc_cnt <= sc_cnt + 4'h1;
  ebtb_timer i_dut (
    .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(), .sub_clock_pin(sc_cnt[3]), .op_mode(op_mode),
    .divided_clock_out_pin(clk_out), .irq(irq)
  );
  function automatic int per(input logic [2:0] s);
    return s[2] ? (512 >> s[1:0]) : (32 >> s[1:0]);
  endfunction
  task automatic rdy;
    int t;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (hready !== 1'b1 && t < 100);
    if (hready !== 1'b1) err_count++;
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'b00};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rv = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input logic [31:0] got);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, `EBTB_IDX_MODE, 32'h0);
    chk("mode", 32'h10, rv);
    bus(1'b0, `EBTB_IDX_COUNT, 32'h0);
    chk("count", 32'h0, rv);
    bus(1'b0, 16'h0001, 32'h0);
    chk("unmapped", 32'h0, rv);
    bus(1'b1, `EBTB_IDX_MODE, 32'hef);
    bus(1'b1, `EBTB_IDX_COUNT, 32'h55);
    bus(1'b0, `EBTB_IDX_COUNT, 32'h0);
    chk("count", 32'h0, rv);
    bus(1'b0, `EBTB_IDX_MODE, 32'h0);
    chk("mode", 32'hff, rv);
    bus(1'b1, `EBTB_IDX_MODE, 32'h00);
    bus(1'b0, `EBTB_IDX_MODE, 32'h0);
    chk("mode", 32'h10, rv);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `EBTB_IDX_MODE, 32'h0c);
      bus(1'b1, `EBTB_IDX_MODE, i);
      repeat (4 * dv[i]) @(posedge clock);
      bus(1'b0, `EBTB_IDX_COUNT, 32'h0);
      rng("interval_count", 4, 5, rv);
    end
    bus(1'b1, `EBTB_IDX_MASK, 32'h1);
    bus(1'b1, `EBTB_IDX_MODE, 32'h0c);
    bus(1'b1, `EBTB_IDX_MODE, 32'h07);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    rng("overflow_cycles", 2040, 2058, n);
    bus(1'b0, `EBTB_IDX_COUNT, 32'h0);
    rng("wrapped_count", 0, 1, rv);
    bus(1'b0, `EBTB_IDX_STATUS, 32'h0);
    chk("status", 32'h1, rv);
    bus(1'b1, `EBTB_IDX_MASK, 32'h0);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, irq);
    bus(1'b1, `EBTB_IDX_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, irq);
    op_mode <= `EBTB_OPM_SUBACTIVE;
    bus(1'b0, `EBTB_IDX_COUNT, 32'h0);
    chk("sub_count", 32'h0, rv);
    op_mode <= `EBTB_OPM_ACTIVE;
    bus(1'b1, `EBTB_IDX_MODE, 32'h0c);
    bus(1'b1, `EBTB_IDX_STATUS, 32'h1);
    repeat (3) @(posedge clock);
    chk("irq", 32'h0, irq);
    bus(1'b0, `EBTB_IDX_STATUS, 32'h0);
    chk("status", 32'h0, rv);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `EBTB_IDX_MODE, 32'h0c + i);
      bus(1'b1, `EBTB_IDX_MODE, 32'h08 + i);
      repeat (64 * sd[i]) @(posedge clock);
      bus(1'b0, `EBTB_IDX_COUNT, 32'h0);
      rng("base_count", 3, 4, rv);
    end
    for (int i = 0; i < 12; i++) begin
      op_mode <= om[i];
      bus(1'b1, `EBTB_IDX_CONTROL, {31'h0, i != 11});
      // interval mode: a time-base hold would freeze the subclock taps
      bus(1'b1, `EBTB_IDX_MODE, {24'h0, sel[i], 5'h00});
      repeat (4) @(posedge clock);
      n = 0;
      prev = clk_out;
      repeat (8 * per(sel[i])) begin
        @(posedge clock);
        if (clk_out === 1'b1 && prev === 1'b0) n++;
        prev = clk_out;
      end
      rng("clock_rises", (i == 9 || i == 11) ? 0 : 7, (i == 9 || i == 11) ? 0 : 9, n);
    end
    give_verdict();
  end
  initial begin
    repeat (95000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
